// [logic/ohc_list_sched_ctrl.sv]
// How it works
// R1: State field 7:6, reset 00b, resume 01b
// R2: Frame tokens start 1 ms after operational
// R3: Set frame-start flag when tokens begin
// R4: Hardware changes state only from suspend
// R5: Suspend moves to resume on downstream resume
// R6: Software reset leaves state at suspend
// R7: Hardware reset: reset state, hub, port reset
// R8: Bulk enable bit 5, sampled per frame
// R9: Driver advances bulk pointer before re-enable
// R10: Control enable bit 4, sampled per frame
// R11: Driver advances control pointer before re-enable
// R12: Isochronous descriptor with bit 3 clear halts periodic
// R13: Isochronous enable acts from next frame
// R14: Periodic enable bit 2, sampled at frame start
// R15: Bits 1:0 select 1..4 control per bulk
// R16: Compare ratio with served count before pick
// R17: Served count kept across frames
// R18: Driver restores ratio after any reset
// R19: No list processing outside operational
`timescale 1ns/1ps
`default_nettype none
module ohc_list_sched_ctrl #(
	parameter int SOF_DELAY_CYC = ohc_pkg::OHC_SOF_DELAY_CYC,
	parameter int FRAME_CYC = ohc_pkg::OHC_FRAME_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic sw_reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rd_ack,
	input wire logic resume_detect,
	input wire logic frame_start_flag_clr,
	output logic frame_start_flag,
	output logic sof_pulse,
	output ohc_pkg::ohc_fstate_t functional_state,
	output ohc_pkg::ohc_en_t frame_en,
	input wire logic iso_ed_hit,
	output logic periodic_halt,
	input wire logic np_req,
	input wire logic ctrl_avail,
	input wire logic bulk_avail,
	output logic pick_ack,
	output logic pick_ctrl,
	output logic pick_bulk,
	output logic root_hub_rst,
	output logic port_rst
);

	logic rst_s1_reg, rst_n;
	logic res_s1_reg, res_s2_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_reg <= 1'b0;
			rst_n <= 1'b0;
			res_s1_reg <= 1'b0;
			res_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n <= rst_s1_reg;
			res_s1_reg <= resume_detect;
			res_s2_reg <= res_s1_reg;
		end
	end

	// Control register and functional state
	logic [31:0] ctrl_reg, ctrl_next;
	logic [31:0] rdata_reg, rdata_next;
	logic rd_ack_reg, rd_ack_next;
	ohc_pkg::ohc_fstate_t fs_reg, fs_next;
	logic wr_hit;

	assign wr_hit = reg_wr && reg_addr == ohc_pkg::OHC_CTRL_OFS;

	always_comb begin
		ctrl_next = ctrl_reg;
		fs_next = fs_reg;
		if (sw_reset) begin
			ctrl_next = ohc_pkg::OHC_CTRL_RESET;
			fs_next = ohc_pkg::OHC_FS_SUSPENDED; // see R6
		end else if (wr_hit) begin
			ctrl_next = reg_wdata & ohc_pkg::OHC_CTRL_WMASK;
			fs_next = ohc_pkg::ohc_fstate_t'(reg_wdata[ohc_pkg::OHC_FS_LSB +: 2]); // see R1
		end else if (fs_reg == ohc_pkg::OHC_FS_SUSPENDED && res_s2_reg) begin
			// Only autonomous change the state ever makes
			fs_next = ohc_pkg::OHC_FS_RESUMING; // see R4, R5
		end
		rdata_next = 32'h00000000;
		if (reg_rd && reg_addr == ohc_pkg::OHC_CTRL_OFS) begin
			rdata_next = ctrl_reg;
			rdata_next[ohc_pkg::OHC_FS_LSB +: 2] = fs_reg;
		end
		rd_ack_next = reg_rd;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= ohc_pkg::OHC_CTRL_RESET;
			fs_reg <= ohc_pkg::OHC_FS_IN_RESET; // see R7
			rdata_reg <= 32'h00000000;
			rd_ack_reg <= 1'b0;
		end else if (!rst_n) begin
			ctrl_reg <= ohc_pkg::OHC_CTRL_RESET;
			fs_reg <= ohc_pkg::OHC_FS_IN_RESET;
			rdata_reg <= 32'h00000000;
			rd_ack_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			fs_reg <= fs_next;
			rdata_reg <= rdata_next;
			rd_ack_reg <= rd_ack_next;
		end
	end

	// Root hub reset then downstream reset signalling
	logic [4:0] rh_cnt_reg, rh_cnt_next;
	logic rh_rst_reg, rh_rst_next, port_rst_reg, port_rst_next;

	always_comb begin
		rh_cnt_next = rh_cnt_reg;
		rh_rst_next = 1'b0;
		if (rh_cnt_reg != 5'h00) begin
			rh_cnt_next = rh_cnt_reg - 5'h01;
			rh_rst_next = 1'b1; // see R7
		end
		port_rst_next = !rh_rst_next && fs_next == ohc_pkg::OHC_FS_IN_RESET; // see R7
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rh_cnt_reg <= 5'(ohc_pkg::OHC_RH_RST_CYC);
			rh_rst_reg <= 1'b1;
			port_rst_reg <= 1'b0;
		end else if (!rst_n) begin
			rh_cnt_reg <= 5'(ohc_pkg::OHC_RH_RST_CYC);
			rh_rst_reg <= 1'b1;
			port_rst_reg <= 1'b0;
		end else begin
			rh_cnt_reg <= rh_cnt_next;
			rh_rst_reg <= rh_rst_next;
			port_rst_reg <= port_rst_next;
		end
	end

	// Frame timing
	logic [ohc_pkg::OHC_CNT_W-1:0] tmr_reg, tmr_next;
	logic sof_on_reg, sof_on_next, sof_reg, sof_next, sf_reg, sf_next;
	logic running;

	assign running = fs_reg == ohc_pkg::OHC_FS_RUNNING;

	always_comb begin
		tmr_next = tmr_reg;
		sof_on_next = sof_on_reg;
		sof_next = 1'b0;
		if (!running) begin
			sof_on_next = 1'b0;
			tmr_next = ohc_pkg::OHC_CNT_W'(SOF_DELAY_CYC - 1);
		end else if (tmr_reg != '0) begin
			tmr_next = tmr_reg - 1'b1;
		end else begin
			// Delay count on entry, frame count afterwards
			sof_next = 1'b1; // see R2
			sof_on_next = 1'b1;
			tmr_next = ohc_pkg::OHC_CNT_W'(FRAME_CYC - 1);
		end
		// A set in the clearing cycle wins
		sf_next = (sf_reg && !frame_start_flag_clr) || sof_next; // see R3
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tmr_reg <= '0;
			sof_on_reg <= 1'b0;
			sof_reg <= 1'b0;
			sf_reg <= 1'b0;
		end else if (!rst_n) begin
			tmr_reg <= '0;
			sof_on_reg <= 1'b0;
			sof_reg <= 1'b0;
			sf_reg <= 1'b0;
		end else begin
			tmr_reg <= tmr_next;
			sof_on_reg <= sof_on_next;
			sof_reg <= sof_next;
			sf_reg <= sf_next;
		end
	end

	// Per-frame enables and schedule picks
	ohc_pkg::ohc_en_t en_reg, en_next;
	logic halt_reg, halt_next;
	logic [2:0] cnt_reg, cnt_next;
	logic ack_reg, ack_next, pc_reg, pc_next, pb_reg, pb_next;
	logic ctrl_ok, bulk_ok;

	assign ctrl_ok = en_reg.ctrl && ctrl_avail && running; // see R10, R19
	assign bulk_ok = en_reg.bulk && bulk_avail && running; // see R8, R19

	always_comb begin
		en_next = en_reg;
		halt_next = halt_reg;
		if (!running) begin
			en_next = '0; // see R19
		end else if (sof_next) begin
			// While running, enables only move on a frame edge
			en_next.per = ctrl_next[ohc_pkg::OHC_PLE_BIT]; // see R14
			en_next.iso = ctrl_next[ohc_pkg::OHC_IE_BIT]; // see R13
			en_next.ctrl = ctrl_next[ohc_pkg::OHC_CLE_BIT]; // see R10
			en_next.bulk = ctrl_next[ohc_pkg::OHC_BLE_BIT]; // see R8
			halt_next = 1'b0;
		end else if (iso_ed_hit && en_reg.per && !en_reg.iso) begin
			halt_next = 1'b1; // see R12
		end
		cnt_next = cnt_reg; // see R17
		ack_next = np_req;
		pc_next = 1'b0;
		pb_next = 1'b0;
		if (np_req) begin
			if (ctrl_ok && (!bulk_ok || cnt_reg <= {1'b0, ctrl_reg[1:0]})) begin
				pc_next = 1'b1; // see R15, R16
				cnt_next = cnt_reg + 3'h1;
			end else if (bulk_ok) begin
				pb_next = 1'b1; // see R16
				cnt_next = 3'h0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			en_reg <= '0;
			halt_reg <= 1'b0;
			cnt_reg <= 3'h0;
			ack_reg <= 1'b0;
			pc_reg <= 1'b0;
			pb_reg <= 1'b0;
		end else if (!rst_n) begin
			en_reg <= '0;
			halt_reg <= 1'b0;
			cnt_reg <= 3'h0;
			ack_reg <= 1'b0;
			pc_reg <= 1'b0;
			pb_reg <= 1'b0;
		end else begin
			en_reg <= en_next;
			halt_reg <= halt_next;
			cnt_reg <= cnt_next;
			ack_reg <= ack_next;
			pc_reg <= pc_next;
			pb_reg <= pb_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign reg_rd_ack = rd_ack_reg;
	assign frame_start_flag = sf_reg;
	assign sof_pulse = sof_reg;
	assign functional_state = fs_reg;
	assign frame_en = en_reg;
	assign periodic_halt = halt_reg;
	assign pick_ack = ack_reg;
	assign pick_ctrl = pc_reg;
	assign pick_bulk = pb_reg;
	assign root_hub_rst = rh_rst_reg;
	assign port_rst = port_rst_reg;

	sequence s_enter_run;
		!running ##1 running;
	endsequence

	AST_RESET_STATE: assert property (@(posedge clk) $rose(rst_n) |-> fs_reg == ohc_pkg::OHC_FS_IN_RESET) // see R1
		else $error("state not reset after hardware reset");
	AST_SOF_LATE: assert property (@(posedge clk) disable iff (!rst_n)
		s_enter_run |-> !sof_reg [*8]) // see R2
		else $error("frame token too soon after entering operational");
	AST_SOF_FLAG: assert property (@(posedge clk) disable iff (!rst_n) sof_reg |-> sf_reg) // see R3
		else $error("frame-start flag missing with frame token");
	AST_HW_ONLY_SUSPEND: assert property (@(posedge clk) disable iff (!rst_n)
		!$past(wr_hit) && !$past(sw_reset) && fs_reg != $past(fs_reg)
		|-> $past(fs_reg) == ohc_pkg::OHC_FS_SUSPENDED) // see R4
		else $error("state changed by hardware outside suspend");
	AST_RESUME: assert property (@(posedge clk) disable iff (!rst_n)
		fs_reg == ohc_pkg::OHC_FS_SUSPENDED && res_s2_reg && !wr_hit && !sw_reset
		|=> fs_reg == ohc_pkg::OHC_FS_RESUMING) // see R5
		else $error("resume not taken from suspend");
	AST_SW_RESET: assert property (@(posedge clk) disable iff (!rst_n)
		sw_reset |=> fs_reg == ohc_pkg::OHC_FS_SUSPENDED) // see R6
		else $error("software reset did not leave suspend");
	AST_HUB_THEN_PORT: assert property (@(posedge clk) disable iff (!rst_n)
		port_rst_reg |-> !rh_rst_reg) // see R7
		else $error("port reset overlaps root hub reset");
	AST_EN_FRAME_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
		running && $past(running) && !$past(sof_next) |-> $stable(en_reg)) // see R8, R10, R13, R14
		else $error("list enable moved inside a frame");
	AST_ISO_HALT: assert property (@(posedge clk) disable iff (!rst_n)
		iso_ed_hit && running && en_reg.per && !en_reg.iso && !sof_next |=> halt_reg) // see R12
		else $error("periodic list not halted on isochronous descriptor");
	AST_RATIO: assert property (@(posedge clk) disable iff (!rst_n)
		pc_reg |-> $past(cnt_reg) <= {1'b0, $past(ctrl_reg[1:0])} || !$past(bulk_ok)) // see R15, R16
		else $error("control picked beyond ratio");
	AST_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
		!running |=> !pc_reg && !pb_reg) // see R19
		else $error("list picked outside operational");

endmodule
`default_nettype wire

// [logic/ohc_pkg.sv]
package ohc_pkg;

	localparam logic [7:0] OHC_CTRL_OFS = 8'h04;
	localparam int OHC_FS_LSB = 6;
	localparam int OHC_BLE_BIT = 5;
	localparam int OHC_CLE_BIT = 4;
	localparam int OHC_IE_BIT = 3;
	localparam int OHC_PLE_BIT = 2;
	localparam int OHC_RATIO_LSB = 0;
	localparam int OHC_MISC_LSB = 8;
	localparam logic [31:0] OHC_CTRL_RESET = 32'h00000000;
	localparam logic [31:0] OHC_CTRL_WMASK = 32'h000007FF;

	localparam int OHC_CLK_MHZ = 125;
	localparam int OHC_SOF_DELAY_US = 1000;
	localparam int OHC_FRAME_US = 1000;
	localparam int OHC_SOF_DELAY_CYC = OHC_SOF_DELAY_US * OHC_CLK_MHZ;
	localparam int OHC_FRAME_CYC = OHC_FRAME_US * OHC_CLK_MHZ;
	localparam int OHC_RH_RST_CYC = 16;
	localparam int OHC_CNT_W = 17;

	typedef enum logic [1:0] {
		OHC_FS_IN_RESET = 2'b00,
		OHC_FS_RESUMING = 2'b01,
		OHC_FS_RUNNING = 2'b10,
		OHC_FS_SUSPENDED = 2'b11
	} ohc_fstate_t;

	typedef struct packed {
		logic per;
		logic iso;
		logic ctrl;
		logic bulk;
	} ohc_en_t;

endpackage

// [tb/ohc_hub_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ohc_hub_model (
	input wire logic clk,
	input wire logic root_hub_rst,
	input wire logic port_rst,
	input wire logic resume_go,
	output logic resume_detect,
	output logic hub_ok
);
	logic hub_seen = 1'b0;
	always @(posedge clk) begin
		if (root_hub_rst) begin
			hub_seen <= 1'b1;
		end
	end
	// Port reset only counts once the hub itself was reset
	assign hub_ok = hub_seen && port_rst && !root_hub_rst;
	// Resume is a held level, as a waking port gives it
	assign resume_detect = resume_go;
endmodule
`default_nettype wire

// [tb/ohci_list_sched_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module ohci_list_sched_ctrl_bench;
	localparam int SD = 20;
	localparam int FC = 30;
	logic clk = 0, rstn = 0, sw_reset = 0, reg_wr = 0, reg_rd = 0, resume_go = 0, frame_start_flag_clr = 0;
	logic iso_ed_hit = 0, np_req = 0, ctrl_avail = 0, bulk_avail = 0;
	logic [7:0] reg_addr = 8'h04;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
	logic reg_rd_ack, frame_start_flag, sof_pulse, periodic_halt, pick_ack, pick_ctrl, pick_bulk;
	logic root_hub_rst, port_rst, resume_detect, hub_ok;
	ohc_pkg::ohc_fstate_t functional_state;
	ohc_pkg::ohc_en_t frame_en;
	int mismatches = 0, n_compared = 0, n;
	logic [31:0] rd_q[$];
	logic [1:0] pk_q[$];
	ohc_list_sched_ctrl #(.SOF_DELAY_CYC(SD), .FRAME_CYC(FC)) u_ohc_list_sched_ctrl (.clk(clk), .rstn(rstn),
		.sw_reset(sw_reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rd_ack(reg_rd_ack), .resume_detect(resume_detect),
		.frame_start_flag_clr(frame_start_flag_clr), .frame_start_flag(frame_start_flag), .sof_pulse(sof_pulse),
		.functional_state(functional_state), .frame_en(frame_en), .iso_ed_hit(iso_ed_hit),
		.periodic_halt(periodic_halt), .np_req(np_req), .ctrl_avail(ctrl_avail), .bulk_avail(bulk_avail),
		.pick_ack(pick_ack), .pick_ctrl(pick_ctrl), .pick_bulk(pick_bulk), .root_hub_rst(root_hub_rst),
		.port_rst(port_rst));
	ohc_hub_model u_ohc_hub_model (.clk(clk), .root_hub_rst(root_hub_rst), .port_rst(port_rst),
		.resume_go(resume_go), .resume_detect(resume_detect), .hub_ok(hub_ok));
	always #4 clk = ~clk;
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_rdata(input logic [31:0] e);
		chk("rdata", e, reg_rdata);
	endtask
	task automatic chk_pick(input logic [1:0] e);
		chk("pick", {30'h0, e}, {30'h0, pick_ctrl, pick_bulk});
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		cyc(1);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		cyc(1);
		reg_wr = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		cyc(1);
		reg_addr = a;
		reg_rd = 1;
		rd_q.push_back(e);
		cyc(1);
		reg_rd = 0;
	endtask
	task automatic pk(input logic c, input logic b, input logic [1:0] e);
		cyc(1);
		ctrl_avail = c;
		bulk_avail = b;
		np_req = 1;
		pk_q.push_back(e);
		cyc(1);
		np_req = 0;
	endtask
	task automatic wait_sof;
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (sof_pulse !== 1'b1 && n < 200);
	endtask
	task automatic iso_hit;
		cyc(1);
		iso_ed_hit = 1;
		cyc(1);
		iso_ed_hit = 0;
		cyc(1);
	endtask
	task automatic final_report;
		// Notes never answered count as misses
		mismatches += rd_q.size() + pk_q.size();
		$display("Compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Results checked in request order
	always begin
		@(posedge clk);
		#2;
		if (reg_rd_ack === 1'b1) begin
			chk_rdata(rd_q.size() ? rd_q.pop_front() : 32'hX);
		end
		if (pick_ack === 1'b1) begin
			chk_pick(pk_q.size() ? pk_q.pop_front() : 2'hX);
		end
	end
	initial begin
		#200000;
		mismatches++;
		final_report;
	end
	initial begin
		v = $urandom(26);
		cyc(6);
		chk("hub_rst", 1, root_hub_rst);
		rstn = 1;
		cyc(3);
		for (int i = 0; i < 40 && hub_ok !== 1'b1; i++) cyc(1);
		chk("hub_ok", 1, hub_ok);
		chk("state", 2'b00, functional_state);
		rd(8'h04, 32'h0);
		for (int i = 0; i < 3; i++) begin
			v = $urandom | 32'hC0;
			wr(8'h04, v);
			rd(8'h04, v & ohc_pkg::OHC_CTRL_WMASK);
		end
		wr(8'h08, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h04, v & ohc_pkg::OHC_CTRL_WMASK);
		pk(1, 1, 2'b00);
		wr(8'h04, 32'hBC);
		wait_sof;
		// First token lands exactly the delay count after the write edge
		chk("sof_delay", SD, n);
		chk("flag", 1, frame_start_flag);
		chk("frame_en", 4'hF, frame_en);
		wait_sof;
		chk("frame_gap", FC, n);
		cyc(1);
		frame_start_flag_clr = 1;
		cyc(1);
		frame_start_flag_clr = 0;
		chk("flag", 0, frame_start_flag);
		iso_hit;
		chk("halt", 0, periodic_halt);
		for (int c = 0; c < 4; c++) begin
			wr(8'h04, 32'hBC | c);
			pk(0, 1, 2'b01);
			for (int k = 0; k <= c; k++) pk(1, 1, 2'b10);
			if (c == 3) wait_sof;
			pk(1, 1, 2'b01);
		end
		wait_sof;
		// Only the next frame token may take these changes
		wr(8'h04, 32'h84);
		chk("frame_en", 4'hF, frame_en);
		pk(1, 1, 2'b10);
		wait_sof;
		chk("frame_en", 4'h8, frame_en);
		pk(1, 1, 2'b00);
		iso_hit;
		chk("halt", 1, periodic_halt);
		wait_sof;
		chk("halt", 0, periodic_halt);
		// Current pointers already moved past removed descriptors
		wr(8'h04, 32'hB4);
		pk(1, 1, 2'b00);
		cyc(1);
		sw_reset = 1;
		cyc(1);
		sw_reset = 0;
		chk("state", 2'b11, functional_state);
		rd(8'h04, 32'hC0);
		wr(8'h04, 32'hC3);
		rd(8'h04, 32'hC3);
		cyc(8);
		chk("state", 2'b11, functional_state);
		pk(1, 1, 2'b00);
		resume_go = 1;
		for (int i = 0; i < 10 && functional_state !== 2'b01; i++) cyc(1);
		chk("state", 2'b01, functional_state);
		resume_go = 0;
		cyc(3);
		final_report;
	end
endmodule
`default_nettype wire
